// ### bench/ntg_gate_props.sv
// Concurrent checks bound to the near-field command gate
`timescale 1ns/10ps
module ntg_gate_props
  import ntg_pkg::*;
#(
  parameter logic [7:0] LAST_BLOCK = 8'h62
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire ntg_frame_s  frame_i,
  input wire logic        field_init_i,
  input wire logic        mem_busy_i,
  input wire logic        field_low_i,
  input wire ntg_reply_s  reply_o,
  input wire ntg_mem_s    mem_o,
  input wire logic [31:0] nearfield_write_share_lock_o,
  input wire ntg_state_e  state_o
);
  // ----------
  // Frame and lock-word checks
  // ----------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go;
  logic act;
  logic rdc;
  assign go  = frame_i.valid && !field_init_i;
  assign act = go && state_o == NTG_ACTIVE && !frame_i.err;
  assign rdc = frame_i.cmd == 8'h30;
  property p_idle_drop;
    go && state_o == NTG_IDLE && !(frame_i.cmd inside {8'h26, 8'h52}) |=> !reply_o.valid;
  endproperty
  a_idle_drop: assert property (p_idle_drop) else $error("reply in idle");
  property p_ready_read;
    go && state_o == NTG_READY && rdc && frame_i.arg != 8'h00 |=> !reply_o.valid && !mem_o.rd;
  endproperty
  a_ready_read: assert property (p_ready_read) else $error("ready read");
  property p_bad_addr;
    act && rdc && frame_i.arg > LAST_BLOCK |=> reply_o.valid && reply_o.code == 4'h0;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("bad address code");
  property p_crc;
    go && state_o == NTG_ACTIVE && rdc && frame_i.err |=> reply_o.valid && reply_o.code == 4'h1;
  endproperty
  a_crc: assert property (p_crc) else $error("crc code");
  property p_busy;
    act && rdc && frame_i.arg <= LAST_BLOCK && mem_busy_i
      |=> reply_o.valid && reply_o.code == 4'h4;
  endproperty
  a_busy: assert property (p_busy) else $error("busy code");
  // Three samples cover the two-flop synchroniser on the power flag
  property p_low_power;
    field_low_i [*3] ##0 (act && frame_i.cmd == 8'hA2 && frame_i.arg < 8'h40 && !mem_busy_i)
      |=> reply_o.valid && reply_o.code == 4'h5;
  endproperty
  a_low_power: assert property (p_low_power) else $error("power code");
  property p_nfw_fixed;
    nearfield_write_share_lock_o[23] && !nearfield_write_share_lock_o[26];
  endproperty
  a_nfw_fixed: assert property (p_nfw_fixed) else $error("fixed lock bits");
  property p_ackval_reply;
    reply_o.valid && reply_o.kind == NTG_RPL_ACKVAL
      |-> $past(state_o) == NTG_PRIVACY && state_o == NTG_IDLE;
  endproperty
  a_ackval_reply: assert property (p_ackval_reply) else $error("ackval reply");
endmodule : ntg_gate_props
bind ntg_gate ntg_gate_props #(.LAST_BLOCK(LAST_BLOCK)) chk_u (.clk_i, .rst_i, .frame_i,
  .field_init_i, .mem_busy_i, .field_low_i, .reply_o, .mem_o,
  .nearfield_write_share_lock_o, .state_o);

// ### bench/ntg_gate_tb.sv
// Self-checking bench of the near-field command gate
`timescale 1ns/10ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; \
  $display("[FAIL] %0t got %0h want %0h", $time, a, b); end end
module ntg_gate_tb
  import ntg_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, init, busy, low, wb_ack_o;
  logic [7:0]  adr;
  logic [31:0] dat, q, wb_dat_o, nfw;
  logic [15:0] cl[4] = '{16'h9320, 16'h9370, 16'h9520, 16'h9570};
  int          errors = 0;
  int          checks = 0;
  ntg_frame_s  frame;
  ntg_reply_s  reply_o;
  ntg_mem_s    mem_o;
  ntg_state_e  state_o;

  ntg_gate dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o, .wb_ack_o,
    .frame_i(frame), .field_init_i(init), .mem_busy_i(busy), .field_low_i(low),
    .reply_o, .mem_o, .nearfield_write_share_lock_o(nfw), .state_o);
  ntg_reader rdr_u (.clk_i, .frame_o(frame));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // ----------
  // Bus and frame tasks
  // ----------
  task automatic end_sim;
    if (errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      `CHK(n, 0)
      end_sim();
    end
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask : rd
  task automatic fr(input logic [7:0] c, a, input logic [31:0] d = 0, input logic s = 0,
                    input logic e = 0, input int g = 0);
    rdr_u.send(c, a, d, s, e, g);
    #1;
  endtask : fr
  task automatic rep(input logic v, input logic [3:0] c = 4'h0,
                     input ntg_reply_e k = NTG_RPL_CODE);
    `CHK(reply_o.valid, v)
    if (v) `CHK(reply_o.kind, k)
    if (v && k == NTG_RPL_CODE) `CHK(reply_o.code, c)
  endtask : rep
  task automatic up;
    fr(8'h52, 8'h00);
    fr(8'h95, 8'h70);
  endtask : up
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1C);
    rd(8'h08, 32'h00800000);
    wb(1'b1, 8'h04, 32'h0);
    rd(8'h04, 32'h1C);
    wb(1'b1, 8'h00, 32'hFFFFFFFF);
    rd(8'h00, 32'h0000FFFF);
    wb(1'b1, 8'h08, 32'h0);
    rd(8'h08, 32'h00800000);
    wb(1'b1, 8'h08, 32'hFFFFFFFF);
    #1;
    `CHK(nfw, 32'hFBFFFFFF)
    rd(8'h40, 32'h0);
    wb(1'b1, 8'h00, 32'h8);
    wb(1'b1, 8'h04, 32'h2);
  endtask : t_regs
  task automatic t_boot;
    fr(8'hA2, 8'h05);
    rep(1'b0);
    `CHK(state_o, NTG_IDLE)
    fr(8'h26, 8'h00);
    `CHK(state_o, NTG_READY)
    fr(8'h30, 8'h05);
    rep(1'b0);
    `CHK(state_o, NTG_IDLE)
    fr(8'h52, 8'h00, 0, 0, 0, 3);
    fr(8'h30, 8'h00);
    rep(1'b1, 4'h0, NTG_RPL_DATA);
    foreach (cl[i]) begin
      fr(cl[i][15:8], cl[i][7:0]);
      `CHK(reply_o.valid, 1'b1)
    end
    `CHK(state_o, NTG_ACTIVE)
  endtask : t_boot
  task automatic t_active;
    fr(8'h30, 8'h63);
    rep(1'b1, 4'h0);
    fr(8'h30, 8'h63, 0, 0, 1);
    rep(1'b1, 4'h1);
    @(posedge clk_i);
    busy <= 1'b1;
    fr(8'h30, 8'h05);
    rep(1'b1, 4'h4);
    @(posedge clk_i);
    busy <= 1'b0;
    low <= 1'b1;
    fr(8'hA2, 8'h05, 0, 0, 0, 3);
    rep(1'b1, 4'h5);
    @(posedge clk_i);
    low <= 1'b0;
    fr(8'hA2, 8'h41);
    rep(1'b1, 4'h0);
    fr(8'hA2, 8'h43);
    rep(1'b1, 4'h0);
    fr(8'h30, 8'h40);
    `CHK({mem_o.rd, mem_o.addr, mem_o.zero_mask}, {1'b1, 8'h40, 4'h8})
    fr(8'h30, 8'h44);
    `CHK(mem_o.zero_mask, 4'h0)
    fr(8'hA2, 8'h05, 32'hC0DEF00D);
    rep(1'b1, 4'hA);
    `CHK({mem_o.wr, mem_o.addr, mem_o.wdata}, {1'b1, 8'h05, 32'hC0DEF00D})
    fr(8'hC2, 8'hFF);
    `CHK(reply_o.valid, 1'b1)
    fr(8'h39, 8'h00);
    `CHK(reply_o.valid, 1'b1)
    fr(8'h50, 8'h00);
    `CHK(state_o, NTG_HALT)
  endtask : t_active
  task automatic t_login;
    up();
    fr(8'h1B, 8'h00, 32'h5A5A, 1);
    rep(1'b0);
    `CHK(state_o, NTG_HALT)
    wb(1'b1, 8'h10, 32'h12345678);
    up();
    fr(8'h1B, 8'h00, 32'h12345670);
    rep(1'b1, 4'h0);
    fr(8'h1B, 8'h00, 32'h12345678);
    rep(1'b1, 4'hA);
    `CHK(state_o, NTG_SECURE)
    fr(8'h3F, 8'h00);
    rd(8'h0C, 32'h80);
    wb(1'b1, 8'h14, 32'hBEEF5A5A);
    @(posedge clk_i);
    init <= 1'b1;
    @(posedge clk_i);
    init <= 1'b0;
    #1;
    `CHK(state_o, NTG_PRIVACY)
    fr(8'h26, 8'h00);
    rep(1'b0);
    fr(8'h1B, 8'h00, 32'hBEEF5A5A);
    rep(1'b0);
    fr(8'h1B, 8'h00, 32'hBEEF5A5A, 1);
    rep(1'b1, 4'h0, NTG_RPL_ACKVAL);
    `CHK(reply_o.data, 16'h5A5A)
    `CHK(state_o, NTG_IDLE)
  endtask : t_login

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, init, busy, low} = '0;
    adr = 8'h00;
    dat = 32'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_boot();
    t_active();
    t_login();
    end_sim();
  end
endmodule : ntg_gate_tb

// ### bench/ntg_reader.sv
// Reader model that opens each exchange with one frame pulse
`timescale 1ns/10ps
module ntg_reader
  import ntg_pkg::*;
(
  input  wire logic clk_i,
  output ntg_frame_s frame_o
);
  // ----------
  // Frame issue
  // ----------
  initial frame_o = '0;
  // Fields scrambled between frames so a stale value never looks valid
  task automatic send(input logic [7:0] c, a, input logic [31:0] d, input logic s, e,
                      input int g);
    repeat (g) @(posedge clk_i);
    @(posedge clk_i);
    frame_o <= '{1'b1, c, a, d, s, e};
    @(posedge clk_i);
    frame_o <= '{1'b0, ~c, ~a, ~d, ~s, ~e};
  endtask : send
endmodule : ntg_reader

// ### hw/ntg_defs.svh
// Constants of the near-field command gate: codes, offsets, reset values
`ifndef NTG_DEFS_SVH
`define NTG_DEFS_SVH
// ----------------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------------
`define NTG_CMD_REQ      8'h26
`define NTG_CMD_WAKE     8'h52
`define NTG_CMD_CL1      8'h93
`define NTG_CMD_CL2      8'h95
`define NTG_ARG_ANTICOL  8'h20
`define NTG_ARG_SELECT   8'h70
`define NTG_CMD_HALT     8'h50
`define NTG_ARG_HALT     8'h00
`define NTG_CMD_READ     8'h30
`define NTG_CMD_WRITE    8'hA2
`define NTG_CMD_SECSEL   8'hC2
`define NTG_CMD_COUNTER  8'h39
`define NTG_CMD_PRIVACY  8'h3F
`define NTG_CMD_LOGIN    8'h1B
// ----------------------------------------------------------------------------
// Four-bit answers
// ----------------------------------------------------------------------------
`define NTG_ACK          4'hA
`define NTG_NACK_ARG     4'h0
`define NTG_NACK_CRC     4'h1
`define NTG_NACK_BUSY    4'h4
`define NTG_NACK_POWER   4'h5
// ----------------------------------------------------------------------------
// Block ranges and lock word layout
// ----------------------------------------------------------------------------
`define NTG_UHF_FIRST    8'h40
`define NTG_UHF_LAST     8'h4F
`define NTG_LAST_BLOCK   8'h62
`define NTG_READ_ADDR0   8'h00
`define NTG_RLOCK_MASK   32'h0000FFFF
`define NTG_WLOCK_MASK   32'h0000FFFF
`define NTG_WLOCK_ONES   32'h0000001C
`define NTG_NFW_ONES     32'h00800000
`define NTG_NFW_ZEROS    32'h04000000
`define NTG_PRIV_BIT     7
// ----------------------------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------------------------
`define NTG_OFS_RLOCK    8'h00
`define NTG_OFS_WLOCK    8'h04
`define NTG_OFS_NFWLOCK  8'h08
`define NTG_OFS_CONFIG   8'h0C
`define NTG_OFS_PWD4     8'h10
`define NTG_OFS_PWD2     8'h14
`define NTG_OFS_STATUS   8'h18
`define NTG_RST_RLOCK    32'h00000000
`define NTG_RST_WLOCK    32'h0000001C
`define NTG_RST_NFWLOCK  32'h00800000
`define NTG_RST_CONFIG   32'h00000000
`define NTG_RST_PWD      32'h00000000
`endif

// ### hw/ntg_gate.sv
// State-gated near-field command front end with lock words and Wishbone slave
//
// Notes on behaviour
// - Reader opens each exchange; tag only answers.
// - Decode two-byte anticollision, select, halt; request, wake-up.
// - Decode read, write, sector, counter, privacy, login.
// - Unpermitted command: not executed, no reply.
// - After drop go idle or halt; privacy state stays.
// - Ready state reads only block zero.
// - Privacy state accepts short-form login only.
// - Active state accepts long-form login only.
// - No-data answer is 4-bit code, ack 1010.
// - Invalid argument answers 0000.
// - Parity or CRC error answers 0001, except on request, wake-up, anticollision, select, halt.
// - Memory busy on UHF side answers 0100.
// - Low field power refuses write with 0101.
// - Read-sharing lock covers blocks 64 to 79.
// - Read-locked UHF block returns all zeros.
// - Write lock blocks writes; 66-68 fixed one.
// - Near-field write lock fixed bits 23, 26.
// - Long login match enters secure state.
// - Short login match enters idle, replies acknowledge value.
// - Initialization enters idle or privacy by bit.
//
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "ntg_defs.svh"
module ntg_gate
  import ntg_pkg::*;
#(
  parameter logic [7:0] LAST_BLOCK = `NTG_LAST_BLOCK
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire ntg_frame_s  frame_i,
  input  wire logic        field_init_i,
  input  wire logic        mem_busy_i,
  input  wire logic        field_low_i,
  output ntg_reply_s       reply_o,
  output ntg_mem_s         mem_o,
  output logic      [31:0] nearfield_write_share_lock_o,
  output ntg_state_e       state_o
);
  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic in_uhf(input logic [7:0] blk);
    in_uhf = (blk >= `NTG_UHF_FIRST) && (blk <= `NTG_UHF_LAST);
  endfunction : in_uhf

  function automatic logic lock_hit(input logic [31:0] word, input logic [7:0] blk);
    logic [7:0] idx;
    idx = blk - `NTG_UHF_FIRST;
    lock_hit = in_uhf(blk) && word[idx[3:0]];
  endfunction : lock_hit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction : merge

  // --------------------------------------------------------------------------
  // Power-low synchroniser
  // --------------------------------------------------------------------------
  logic low_meta_q;
  logic low_sync_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_meta_q <= 1'b0;
      low_sync_q <= 1'b0;
    end else begin
      low_meta_q <= field_low_i;
      low_sync_q <= low_meta_q;
    end
  end

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [31:0] rlock_q, rlock_d;
  logic [31:0] wlock_q, wlock_d;
  logic [31:0] nfw_q,   nfw_d;
  logic [31:0] cfg_q,   cfg_d;
  logic [31:0] pwd4_q,  pwd4_d;
  logic [31:0] pwd2_q,  pwd2_d;
  logic        ack_q,   ack_d;
  logic [31:0] rdat_q,  rdat_d;
  logic        priv_flip;
  logic        bus_wr;

  // Write commits on the edge where the master samples ack high
  assign bus_wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;

  always_comb begin
    rlock_d = rlock_q;
    wlock_d = wlock_q;
    nfw_d   = nfw_q;
    cfg_d   = cfg_q;
    pwd4_d  = pwd4_q;
    pwd2_d  = pwd2_q;
    ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d  = 32'h00000000;
    if (bus_wr) begin
      case (wb_adr_i)
        `NTG_OFS_RLOCK:   rlock_d = merge(rlock_q, wb_dat_i, wb_sel_i) & `NTG_RLOCK_MASK;
        `NTG_OFS_WLOCK:   wlock_d = (merge(wlock_q, wb_dat_i, wb_sel_i) & `NTG_WLOCK_MASK)
                                    | `NTG_WLOCK_ONES;
        `NTG_OFS_NFWLOCK: nfw_d = (merge(nfw_q, wb_dat_i, wb_sel_i) | `NTG_NFW_ONES)
                                  & ~`NTG_NFW_ZEROS;
        `NTG_OFS_CONFIG:  cfg_d = merge(cfg_q, wb_dat_i, wb_sel_i) & 32'h00000080;
        `NTG_OFS_PWD4:    pwd4_d = merge(pwd4_q, wb_dat_i, wb_sel_i);
        `NTG_OFS_PWD2:    pwd2_d = merge(pwd2_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
    // Command toggle wins over a bus write of the same cycle
    if (priv_flip) begin
      cfg_d[`NTG_PRIV_BIT] = !cfg_q[`NTG_PRIV_BIT];
    end
    if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
      case (wb_adr_i)
        `NTG_OFS_RLOCK:   rdat_d = rlock_q;
        `NTG_OFS_WLOCK:   rdat_d = wlock_q;
        `NTG_OFS_NFWLOCK: rdat_d = nfw_q;
        `NTG_OFS_CONFIG:  rdat_d = cfg_q;
        `NTG_OFS_STATUS:  rdat_d = {26'h0000000, state_o};
        // Passwords are write only so a reader can never fish them out
        default:          rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rlock_q <= `NTG_RST_RLOCK;
      wlock_q <= `NTG_RST_WLOCK;
      nfw_q   <= `NTG_RST_NFWLOCK;
      cfg_q   <= `NTG_RST_CONFIG;
      pwd4_q  <= `NTG_RST_PWD;
      pwd2_q  <= `NTG_RST_PWD;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h00000000;
    end else begin
      rlock_q <= rlock_d;
      wlock_q <= wlock_d;
      nfw_q   <= nfw_d;
      cfg_q   <= cfg_d;
      pwd4_q  <= pwd4_d;
      pwd2_q  <= pwd2_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  assign wb_ack_o                     = ack_q;
  assign wb_dat_o                     = rdat_q;
  assign nearfield_write_share_lock_o = nfw_q;

  // --------------------------------------------------------------------------
  // Command state machine
  // --------------------------------------------------------------------------
  ntg_state_e state_q, state_d;
  logic       from_halt_q, from_halt_d;
  ntg_reply_s reply_q, reply_d;
  ntg_mem_s   mem_q,   mem_d;
  logic       permit;
  logic       crc_short;
  logic [7:0] blk;

  assign blk = frame_i.arg;

  always_comb begin
    state_d     = state_q;
    from_halt_d = from_halt_q;
    reply_d     = '0;
    mem_d       = '0;
    permit      = 1'b0;
    crc_short   = 1'b0;
    priv_flip   = 1'b0;
    // Reader always speaks first; apart from field initialization nothing happens without a frame
    if (field_init_i) begin
      state_d     = cfg_q[`NTG_PRIV_BIT] ? NTG_PRIVACY : NTG_IDLE;
      from_halt_d = 1'b0;
    end else if (frame_i.valid) begin
      case (frame_i.cmd)
        `NTG_CMD_REQ:     permit = (state_q == NTG_IDLE);
        `NTG_CMD_WAKE:    permit = (state_q == NTG_IDLE) || (state_q == NTG_HALT);
        `NTG_CMD_CL1,
        `NTG_CMD_CL2:     permit = (state_q == NTG_READY) &&
                                   ((frame_i.arg == `NTG_ARG_ANTICOL) ||
                                    (frame_i.arg == `NTG_ARG_SELECT));
        `NTG_CMD_HALT:    permit = (frame_i.arg == `NTG_ARG_HALT) &&
                                   ((state_q == NTG_ACTIVE) || (state_q == NTG_SECURE));
        `NTG_CMD_READ:    permit = (state_q == NTG_ACTIVE) || (state_q == NTG_SECURE) ||
                                   ((state_q == NTG_READY) && (blk == `NTG_READ_ADDR0));
        `NTG_CMD_WRITE,
        `NTG_CMD_SECSEL,
        `NTG_CMD_COUNTER: permit = (state_q == NTG_ACTIVE) || (state_q == NTG_SECURE);
        `NTG_CMD_PRIVACY: permit = (state_q == NTG_SECURE);
        `NTG_CMD_LOGIN:   permit = ((state_q == NTG_PRIVACY) && frame_i.short_form) ||
                                   ((state_q == NTG_ACTIVE) && !frame_i.short_form);
        default:          permit = 1'b0;
      endcase
      crc_short = frame_i.err && !((frame_i.cmd == `NTG_CMD_REQ) ||
                  (frame_i.cmd == `NTG_CMD_WAKE) || (frame_i.cmd == `NTG_CMD_CL1) ||
                  (frame_i.cmd == `NTG_CMD_CL2) || (frame_i.cmd == `NTG_CMD_HALT));
      if (!permit) begin
        // Silent drop; privacy is left only by a good short login or by initialization
        if (state_q != NTG_PRIVACY) begin
          state_d = from_halt_q ? NTG_HALT : NTG_IDLE;
        end
      end else if (crc_short) begin
        reply_d = '{1'b1, NTG_RPL_CODE, `NTG_NACK_CRC, 16'h0000};
      end else if (frame_i.err) begin
        // Corrupt request, wake-up, anticollision, select and halt frames are ignored without a word
        state_d = state_q;
      end else begin
        reply_d = '{1'b1, NTG_RPL_CODE, `NTG_ACK, 16'h0000};
        case (frame_i.cmd)
          `NTG_CMD_REQ, `NTG_CMD_WAKE: begin
            from_halt_d  = (state_q == NTG_HALT);
            state_d      = NTG_READY;
            reply_d.kind = NTG_RPL_ISO;
          end
          `NTG_CMD_CL1, `NTG_CMD_CL2: begin
            reply_d.kind = NTG_RPL_ISO;
            if ((frame_i.cmd == `NTG_CMD_CL2) && (frame_i.arg == `NTG_ARG_SELECT)) begin
              state_d = NTG_ACTIVE;
            end
          end
          `NTG_CMD_HALT: begin
            reply_d.valid = 1'b0;
            state_d       = NTG_HALT;
            from_halt_d   = 1'b1;
          end
          `NTG_CMD_READ: begin
            if (blk > LAST_BLOCK) begin
              reply_d.code = `NTG_NACK_ARG;
            end else if (mem_busy_i) begin
              reply_d.code = `NTG_NACK_BUSY;
            end else begin
              reply_d.kind = NTG_RPL_DATA;
              mem_d.rd     = 1'b1;
              mem_d.addr   = blk;
              for (int i = 0; i < 4; i++) begin
                mem_d.zero_mask[i] = lock_hit(rlock_q, 8'(blk + 8'(i)));
              end
            end
          end
          `NTG_CMD_WRITE: begin
            if ((blk > LAST_BLOCK) || lock_hit(wlock_q, blk)) begin
              reply_d.code = `NTG_NACK_ARG;
            end else if (mem_busy_i) begin
              reply_d.code = `NTG_NACK_BUSY;
            end else if (low_sync_q) begin
              reply_d.code = `NTG_NACK_POWER;
            end else begin
              mem_d.wr    = 1'b1;
              mem_d.addr  = blk;
              mem_d.wdata = frame_i.data;
            end
          end
          `NTG_CMD_COUNTER: begin
            reply_d.kind = NTG_RPL_CNT;
          end
          `NTG_CMD_PRIVACY: begin
            priv_flip = 1'b1;
          end
          `NTG_CMD_LOGIN: begin
            if (frame_i.short_form) begin
              if (frame_i.data == pwd2_q) begin
                state_d = NTG_IDLE;
                reply_d = '{1'b1, NTG_RPL_ACKVAL, `NTG_ACK, pwd2_q[15:0]};
              end else begin
                reply_d.code = `NTG_NACK_ARG;
              end
            end else if (frame_i.data == pwd4_q) begin
              state_d = NTG_SECURE;
            end else begin
              reply_d.code = `NTG_NACK_ARG;
            end
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q     <= NTG_IDLE;
      from_halt_q <= 1'b0;
      reply_q     <= '0;
      mem_q       <= '0;
    end else begin
      state_q     <= state_d;
      from_halt_q <= from_halt_d;
      reply_q     <= reply_d;
      mem_q       <= mem_d;
    end
  end

  // Serialiser downstream sends code bit 3 first
  assign reply_o = reply_q;
  assign mem_o   = mem_q;
  assign state_o = state_q;
endmodule : ntg_gate

// ### hw/ntg_pkg.sv
// Types shared by the near-field command gate and its neighbours
package ntg_pkg;
  typedef enum logic [5:0] {
    NTG_PRIVACY = 6'h01,
    NTG_IDLE    = 6'h02,
    NTG_HALT    = 6'h04,
    NTG_READY   = 6'h08,
    NTG_ACTIVE  = 6'h10,
    NTG_SECURE  = 6'h20
  } ntg_state_e;

  typedef enum logic [2:0] {
    NTG_RPL_ISO  = 3'h0,
    NTG_RPL_CODE = 3'h1,
    NTG_RPL_DATA = 3'h2,
    NTG_RPL_ACKVAL = 3'h3,
    NTG_RPL_CNT  = 3'h4
  } ntg_reply_e;

  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [7:0]  arg;
    logic [31:0] data;
    logic        short_form;
    logic        err;
  } ntg_frame_s;

  typedef struct packed {
    logic        valid;
    ntg_reply_e  kind;
    logic [3:0]  code;
    logic [15:0] data;
  } ntg_reply_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  zero_mask;
  } ntg_mem_s;
endpackage : ntg_pkg
